// *** hdl/vsm_pkg.sv ***
// constants for the watch and soft flag register bank
`default_nettype none
package vsm_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFS_CTRL  = 16'h1000;
  localparam logic [15:0] OFS_STAT  = 16'h1001;
  localparam logic [15:0] OFS_BASEH = 16'h1002;
  localparam logic [15:0] OFS_BASEL = 16'h1003;
  localparam logic [15:0] OFS_SEMAPHORE_ONE_VALUE  = 16'h1004;
  localparam logic [15:0] OFS_SEMAPHORE_TWO_VALUE  = 16'h1005;
  localparam logic [15:0] OFS_SLOT  = 16'h1006;
  // bit positions inside control (set/clear), lower base (watch enable) and semaphores (msb)
  localparam int B_SET_S1 = 7;
  localparam int B_SET_S0 = 6;
  localparam int B_SET_W1 = 5;
  localparam int B_SET_W0 = 4;
  localparam int B_CLR_S1 = 3;
  localparam int B_CLR_S0 = 2;
  localparam int B_CLR_W1 = 1;
  localparam int B_CLR_W0 = 0;
  localparam int B_WEN    = 3;
  localparam int B_SEM    = 7;
  localparam logic [3:0] WATCH_OFS_ZERO = 4'h1;
  localparam logic [3:0] WATCH_OFS_ONE  = 4'h3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // flag order inside a 4-bit group: {soft1, soft0, watch1, watch0}
  localparam int F_S1 = 3;
  localparam int F_S0 = 2;
  localparam int F_W1 = 1;
  localparam int F_W0 = 0;
endpackage
`default_nettype wire

// *** hdl/vsm_sync.sv ***
// two flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module vsm_sync #(
  parameter int W = 6
) (
  input  wire logic         mclk_in,
  input  wire logic         rstn_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } vsm_sync_st_t;
  vsm_sync_st_t st_ff;
  vsm_sync_st_t nxt_st;
  initial begin
    if (W < 1) $error("width must be positive");
  end
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d_in;
    nxt_st.s2 = st_ff.s1;
  end
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign q_out = st_ff.s2;
endmodule
`default_nettype wire

// *** hdl/vsm_regs.sv ***
// byte-wide register bank: soft/watch flags, location watch, semaphores, slot address
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module vsm_regs #(
  parameter int SLOT_W = 5
) (
  input  wire logic                         mclk_in,
  input  wire logic                         rstn_in,
  input  wire logic [vsm_pkg::ADDR_W-1:0]   io_addr_in,
  input  wire logic                         io_wr_in,
  input  wire logic                         io_rd_in,
  input  wire logic [7:0]                   io_wdata_in,
  output logic      [7:0]                   io_rdata_out,
  output logic                              io_hit_out,
  input  wire logic                         bus_access_in,
  input  wire logic [15:0]                  bus_addr_in,
  input  wire logic [SLOT_W-1:0]            slot_addr_n_in,
  input  wire logic                         slot_parity_n_in,
  output logic                              irq_one_out,
  output logic                              irq_zero_out
);
  typedef struct packed {
    logic [3:0] flags;
    logic [3:0] enables;
    logic [7:0] base_high;
    logic [3:0] base_low;
    logic       watch_en;
    logic [7:0] sem_one;
    logic [7:0] sem_two;
    logic [7:0] rdata;
  } vsm_state_t;
  vsm_state_t st_ff;
  vsm_state_t nxt_st;
  logic [SLOT_W:0] slot_sync;
  logic [3:0]      set_v;
  logic [3:0]      clr_v;
  logic            hit_zero;
  logic            hit_one;
  logic            base_match;

  initial begin
    if (SLOT_W != 5) $error("slot address width must be 5");
  end

  function automatic logic sel(input logic [15:0] a, input logic [15:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic [7:0] sem_next(input logic [7:0] cur, input logic [7:0] wd);
    // held semaphore refuses a new value with msb set
    if (cur[vsm_pkg::B_SEM] && wd[vsm_pkg::B_SEM]) return cur;
    return wd;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  vsm_sync #(
    .W (SLOT_W + 1)
  ) u_sync (
    .mclk_in (mclk_in),
    .rstn_in (rstn_in),
    .d_in    ({slot_parity_n_in, slot_addr_n_in}),
    .q_out   (slot_sync)
  );

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    base_match = (bus_addr_in[15:8] == st_ff.base_high) && (bus_addr_in[7:4] == st_ff.base_low);
    hit_zero   = bus_access_in && st_ff.watch_en && base_match
                 && (bus_addr_in[3:0] == vsm_pkg::WATCH_OFS_ZERO);
    hit_one    = bus_access_in && st_ff.watch_en && base_match
                 && (bus_addr_in[3:0] == vsm_pkg::WATCH_OFS_ONE);
    set_v = '0;
    clr_v = '0;
    if (io_wr_in && sel(io_addr_in, vsm_pkg::OFS_CTRL)) begin
      set_v = io_wdata_in[vsm_pkg::B_SET_S1:vsm_pkg::B_SET_W0];
      clr_v = io_wdata_in[vsm_pkg::B_CLR_S1:vsm_pkg::B_CLR_W0];
    end
    set_v[vsm_pkg::F_W0] = set_v[vsm_pkg::F_W0] | hit_zero;
    set_v[vsm_pkg::F_W1] = set_v[vsm_pkg::F_W1] | hit_one;
  end

  always_comb begin
    nxt_st = st_ff;
    // set wins over a clear in the same cycle
    nxt_st.flags = (st_ff.flags & ~clr_v) | set_v;
    if (io_wr_in) begin
      if (sel(io_addr_in, vsm_pkg::OFS_STAT)) begin
        nxt_st.enables = io_wdata_in[7:4];
      end
      if (sel(io_addr_in, vsm_pkg::OFS_BASEH)) begin
        nxt_st.base_high = io_wdata_in;
      end
      if (sel(io_addr_in, vsm_pkg::OFS_BASEL)) begin
        nxt_st.base_low = io_wdata_in[7:4];
        nxt_st.watch_en = io_wdata_in[vsm_pkg::B_WEN];
      end
      if (sel(io_addr_in, vsm_pkg::OFS_SEMAPHORE_ONE_VALUE)) begin
        nxt_st.sem_one = sem_next(st_ff.sem_one, io_wdata_in);
      end
      if (sel(io_addr_in, vsm_pkg::OFS_SEMAPHORE_TWO_VALUE)) begin
        nxt_st.sem_two = sem_next(st_ff.sem_two, io_wdata_in);
      end
    end
    nxt_st.rdata = vsm_pkg::RST_BYTE;
    if (io_rd_in) begin
      unique case (1'b1)
        sel(io_addr_in, vsm_pkg::OFS_STAT):  nxt_st.rdata = {st_ff.enables, st_ff.flags};
        sel(io_addr_in, vsm_pkg::OFS_BASEH): nxt_st.rdata = st_ff.base_high;
        sel(io_addr_in, vsm_pkg::OFS_BASEL): nxt_st.rdata = {st_ff.base_low, st_ff.watch_en, 3'h0};
        sel(io_addr_in, vsm_pkg::OFS_SEMAPHORE_ONE_VALUE):  nxt_st.rdata = st_ff.sem_one;
        sel(io_addr_in, vsm_pkg::OFS_SEMAPHORE_TWO_VALUE):  nxt_st.rdata = st_ff.sem_two;
        sel(io_addr_in, vsm_pkg::OFS_SLOT):  nxt_st.rdata = {2'h0, slot_sync};
        default:                             nxt_st.rdata = vsm_pkg::RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign io_rdata_out = st_ff.rdata;
  assign io_hit_out   = (io_addr_in >= vsm_pkg::OFS_CTRL) && (io_addr_in <= vsm_pkg::OFS_SLOT);
  assign irq_one_out  = (st_ff.enables[vsm_pkg::F_S1] & st_ff.flags[vsm_pkg::F_S1])
                      | (st_ff.enables[vsm_pkg::F_W1] & st_ff.flags[vsm_pkg::F_W1]);
  assign irq_zero_out = (st_ff.enables[vsm_pkg::F_S0] & st_ff.flags[vsm_pkg::F_S0])
                      | (st_ff.enables[vsm_pkg::F_W0] & st_ff.flags[vsm_pkg::F_W0]);

  //////////////////////////////////////////////////////////////////////////////
  property p_set_flag;
    @(posedge mclk_in) disable iff (!rstn_in)
      (io_wr_in && io_addr_in == vsm_pkg::OFS_CTRL && io_wdata_in[vsm_pkg::B_SET_S1]) |=> st_ff.flags[vsm_pkg::F_S1];
  endproperty
  a_set_flag: assert property (p_set_flag) else $error("soft flag one not set");

  property p_clr_flag;
    @(posedge mclk_in) disable iff (!rstn_in)
      (io_wr_in && io_addr_in == vsm_pkg::OFS_CTRL && io_wdata_in == 8'h01 && !hit_zero)
        |=> !st_ff.flags[vsm_pkg::F_W0];
  endproperty
  a_clr_flag: assert property (p_clr_flag) else $error("watch flag zero not cleared");

  property p_irq_one;
    @(posedge mclk_in) disable iff (!rstn_in)
      (st_ff.enables[vsm_pkg::F_S1] && st_ff.flags[vsm_pkg::F_S1]) |-> irq_one_out;
  endproperty
  a_irq_one: assert property (p_irq_one) else $error("irq one missing");

  property p_irq_zero;
    @(posedge mclk_in) disable iff (!rstn_in)
      irq_zero_out |-> ((st_ff.enables[vsm_pkg::F_S0] && st_ff.flags[vsm_pkg::F_S0])
                     || (st_ff.enables[vsm_pkg::F_W0] && st_ff.flags[vsm_pkg::F_W0]));
  endproperty
  a_irq_zero: assert property (p_irq_zero) else $error("irq zero without cause");

  property p_soft_hold;
    @(posedge mclk_in) disable iff (!rstn_in)
      (!(io_wr_in && io_addr_in == vsm_pkg::OFS_CTRL)) |=> $stable(st_ff.flags[vsm_pkg::F_S1:vsm_pkg::F_S0]);
  endproperty
  a_soft_hold: assert property (p_soft_hold) else $error("soft flag changed without control write");

  sequence s_hit_one;
    bus_access_in && st_ff.watch_en && bus_addr_in == {st_ff.base_high, st_ff.base_low, vsm_pkg::WATCH_OFS_ONE};
  endsequence
  property p_watch_one;
    @(posedge mclk_in) disable iff (!rstn_in) s_hit_one |=> st_ff.flags[vsm_pkg::F_W1];
  endproperty
  a_watch_one: assert property (p_watch_one) else $error("watch hit one lost");

  property p_watch_off;
    @(posedge mclk_in) disable iff (!rstn_in)
      (!st_ff.watch_en && !st_ff.flags[vsm_pkg::F_W0] && !(io_wr_in && io_addr_in == vsm_pkg::OFS_CTRL))
        |=> !st_ff.flags[vsm_pkg::F_W0];
  endproperty
  a_watch_off: assert property (p_watch_off) else $error("watch flag set while disabled");

  property p_sem_lock;
    @(posedge mclk_in) disable iff (!rstn_in)
      (io_wr_in && io_addr_in == vsm_pkg::OFS_SEMAPHORE_ONE_VALUE && st_ff.sem_one[vsm_pkg::B_SEM] && io_wdata_in[vsm_pkg::B_SEM])
        |=> $stable(st_ff.sem_one);
  endproperty
  a_sem_lock: assert property (p_sem_lock) else $error("held semaphore overwritten");

  //////////////////////////////////////////////////////////////////////////////
  // building blocks for the remaining checks
  sequence s_ctrl_wr;
    io_wr_in && io_addr_in == vsm_pkg::OFS_CTRL;
  endsequence
  sequence s_hit_zero;
    bus_access_in && st_ff.watch_en && bus_addr_in == {st_ff.base_high, st_ff.base_low, vsm_pkg::WATCH_OFS_ZERO};
  endsequence

  // soft flag zero follows its own set bit
  property p_set_s0;
    @(posedge mclk_in) disable iff (!rstn_in)
      (s_ctrl_wr ##0 io_wdata_in[vsm_pkg::B_SET_S0]) |=> st_ff.flags[vsm_pkg::F_S0];
  endproperty
  a_set_s0: assert property (p_set_s0) else $error("soft flag zero not set");

  // watch flag one set from control
  property p_set_w1;
    @(posedge mclk_in) disable iff (!rstn_in)
      (s_ctrl_wr ##0 io_wdata_in[vsm_pkg::B_SET_W1]) |=> st_ff.flags[vsm_pkg::F_W1];
  endproperty
  a_set_w1: assert property (p_set_w1) else $error("watch flag one not set");

  // watch flag zero set from control
  property p_set_w0;
    @(posedge mclk_in) disable iff (!rstn_in)
      (s_ctrl_wr ##0 io_wdata_in[vsm_pkg::B_SET_W0]) |=> st_ff.flags[vsm_pkg::F_W0];
  endproperty
  a_set_w0: assert property (p_set_w0) else $error("watch flag zero not set by control");

  // soft flag one cleared when no set competes
  property p_clr_s1;
    @(posedge mclk_in) disable iff (!rstn_in)
      (s_ctrl_wr ##0 (io_wdata_in[vsm_pkg::B_CLR_S1] && !io_wdata_in[vsm_pkg::B_SET_S1]))
        |=> !st_ff.flags[vsm_pkg::F_S1];
  endproperty
  a_clr_s1: assert property (p_clr_s1) else $error("soft flag one not cleared");

  // soft flag zero cleared when no set competes
  property p_clr_s0;
    @(posedge mclk_in) disable iff (!rstn_in)
      (s_ctrl_wr ##0 (io_wdata_in[vsm_pkg::B_CLR_S0] && !io_wdata_in[vsm_pkg::B_SET_S0]))
        |=> !st_ff.flags[vsm_pkg::F_S0];
  endproperty
  a_clr_s0: assert property (p_clr_s0) else $error("soft flag zero not cleared");

  // watch flag one cleared unless a set or a hit competes
  property p_clr_w1;
    @(posedge mclk_in) disable iff (!rstn_in)
      (s_ctrl_wr ##0 (io_wdata_in[vsm_pkg::B_CLR_W1] && !io_wdata_in[vsm_pkg::B_SET_W1] && !hit_one))
        |=> !st_ff.flags[vsm_pkg::F_W1];
  endproperty
  a_clr_w1: assert property (p_clr_w1) else $error("watch flag one not cleared");

  // enabled watch flag one drives line one
  property p_irq_w1;
    @(posedge mclk_in) disable iff (!rstn_in)
      (st_ff.enables[vsm_pkg::F_W1] && st_ff.flags[vsm_pkg::F_W1]) |-> irq_one_out;
  endproperty
  a_irq_w1: assert property (p_irq_w1) else $error("irq one missing for watch flag");

  // enabled soft flag zero drives line zero
  property p_irq_s0;
    @(posedge mclk_in) disable iff (!rstn_in)
      (st_ff.enables[vsm_pkg::F_S0] && st_ff.flags[vsm_pkg::F_S0]) |-> irq_zero_out;
  endproperty
  a_irq_s0: assert property (p_irq_s0) else $error("irq zero missing for soft flag");

  // line one never rises without an enabled cause
  property p_irq_one_cause;
    @(posedge mclk_in) disable iff (!rstn_in)
      irq_one_out |-> ((st_ff.enables[vsm_pkg::F_S1] && st_ff.flags[vsm_pkg::F_S1])
                    || (st_ff.enables[vsm_pkg::F_W1] && st_ff.flags[vsm_pkg::F_W1]));
  endproperty
  a_irq_one_cause: assert property (p_irq_one_cause) else $error("irq one without cause");

  // hit at offset one sets watch flag zero
  property p_watch_zero;
    @(posedge mclk_in) disable iff (!rstn_in) s_hit_zero |=> st_ff.flags[vsm_pkg::F_W0];
  endproperty
  a_watch_zero: assert property (p_watch_zero) else $error("watch hit zero lost");

  // upper base takes the written byte
  property p_base_high;
    @(posedge mclk_in) disable iff (!rstn_in)
      (io_wr_in && io_addr_in == vsm_pkg::OFS_BASEH) |=> st_ff.base_high == $past(io_wdata_in);
  endproperty
  a_base_high: assert property (p_base_high) else $error("upper base not written");

  // lower base nibble and enable take the written byte
  property p_base_low;
    @(posedge mclk_in) disable iff (!rstn_in)
      (io_wr_in && io_addr_in == vsm_pkg::OFS_BASEL)
        |=> st_ff.base_low == $past(io_wdata_in[7:4]) && st_ff.watch_en == $past(io_wdata_in[vsm_pkg::B_WEN]);
  endproperty
  a_base_low: assert property (p_base_low) else $error("lower base not written");

  // slot read returns the synchronised pins
  property p_slot_view;
    @(posedge mclk_in) disable iff (!rstn_in)
      (io_rd_in && io_addr_in == vsm_pkg::OFS_SLOT) |=> io_rdata_out == {2'h0, $past(slot_sync)};
  endproperty
  a_slot_view: assert property (p_slot_view) else $error("slot read wrong");

  // write-only control reads back as zero
  property p_ctrl_read;
    @(posedge mclk_in) disable iff (!rstn_in)
      (io_rd_in && io_addr_in == vsm_pkg::OFS_CTRL) |=> io_rdata_out == vsm_pkg::RST_BYTE;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read not zero");

  // second semaphore refuses a taken value
  property p_sem_two_lock;
    @(posedge mclk_in) disable iff (!rstn_in)
      (io_wr_in && io_addr_in == vsm_pkg::OFS_SEMAPHORE_TWO_VALUE && st_ff.sem_two[vsm_pkg::B_SEM] && io_wdata_in[vsm_pkg::B_SEM])
        |=> $stable(st_ff.sem_two);
  endproperty
  a_sem_two_lock: assert property (p_sem_two_lock) else $error("held semaphore two overwritten");

  // free semaphore takes any value
  property p_sem_take;
    @(posedge mclk_in) disable iff (!rstn_in)
      (io_wr_in && io_addr_in == vsm_pkg::OFS_SEMAPHORE_ONE_VALUE && !st_ff.sem_one[vsm_pkg::B_SEM])
        |=> st_ff.sem_one == $past(io_wdata_in);
  endproperty
  a_sem_take: assert property (p_sem_take) else $error("free semaphore not written");

  // no read leaves the data output at zero
  property p_rdata_idle;
    @(posedge mclk_in) disable iff (!rstn_in)
      !io_rd_in |=> io_rdata_out == vsm_pkg::RST_BYTE;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
endmodule
`default_nettype wire

// *** test/vsm_far_end.sv ***
// far side model: monitored bus accesses and backplane slot pins
`timescale 1ns/1ps
`default_nettype none
module vsm_far_end (
  input  wire logic        mclk_in,
  output logic             bus_access_out,
  output logic [15:0]      bus_addr_out,
  output logic [4:0]       slot_addr_n_out,
  output logic             slot_parity_n_out
);
  initial begin
    bus_access_out = 1'b0;
    bus_addr_out = 16'h0000;
    {slot_parity_n_out, slot_addr_n_out} = 6'h3F;
  end
  // accesses reach the bank as one-cycle strobes on the monitored bus
  task automatic access(input logic [15:0] a);
    @(posedge mclk_in);
    bus_access_out <= 1'b1;
    bus_addr_out <= a;
    @(posedge mclk_in);
    bus_access_out <= 1'b0;
    bus_addr_out <= ~a; // released, stale address inverted
  endtask
  task automatic set_slot(input logic [5:0] v);
    @(posedge mclk_in);
    {slot_parity_n_out, slot_addr_n_out} <= v;
  endtask
endmodule
`default_nettype wire

// *** test/vsm_regs_test.sv ***
// self-checking bench for the watch and soft flag register bank
`timescale 1ns/1ps
`default_nettype none
module vsm_regs_test;
  logic        mclk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic        io_wr = 1'b0;
  logic        io_rd = 1'b0;
  logic [7:0]  io_wdata = 8'h00;
  logic [7:0]  io_rdata;
  logic        hit;
  logic        bus_acc;
  logic [15:0] bus_addr;
  logic [4:0]  slot_n;
  logic        par_n;
  logic        irq1;
  logic        irq0;
  logic [7:0]  st, bh, bl, s1, s2;
  logic [5:0]  slot = 6'h3F;
  logic [15:0] seed = 16'h0031;
  int          fail_count = 0;
  int          n_tests = 0;

  always #10 mclk_in = ~mclk_in;

  vsm_regs #(.SLOT_W(5)) vsm_regs_inst (.mclk_in(mclk_in), .rstn_in(rstn_in), .io_addr_in(io_addr),
    .io_wr_in(io_wr), .io_rd_in(io_rd), .io_wdata_in(io_wdata), .io_rdata_out(io_rdata),
    .io_hit_out(hit), .bus_access_in(bus_acc), .bus_addr_in(bus_addr), .slot_addr_n_in(slot_n),
    .slot_parity_n_in(par_n), .irq_one_out(irq1), .irq_zero_out(irq0));
  vsm_far_end vsm_far_end_inst (.mclk_in(mclk_in), .bus_access_out(bus_acc), .bus_addr_out(bus_addr),
    .slot_addr_n_out(slot_n), .slot_parity_n_out(par_n));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask
  task automatic irq_chk();
    chk("irq_one", {7'h00, irq1}, {7'h00, (st[7] & st[3]) | (st[5] & st[1])});
    chk("irq_zero", {7'h00, irq0}, {7'h00, (st[6] & st[2]) | (st[4] & st[0])});
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge mclk_in);
    io_wr <= 1'b0;
    case (a)
      16'h1000: st[3:0] = (st[3:0] & ~d[3:0]) | d[7:4];
      16'h1001: st[7:4] = d[7:4];
      16'h1002: bh = d;
      16'h1003: bl = d & 8'hF8;
      16'h1004: if (!(s1[7] && d[7])) s1 = d;
      16'h1005: if (!(s2[7] && d[7])) s2 = d;
      default: ;
    endcase
    #1 irq_chk();
  endtask
  task automatic rd_chk(input logic [15:0] a);
    logic [7:0] e;
    @(posedge mclk_in);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge mclk_in);
    io_rd <= 1'b0;
    #1;
    case (a)
      16'h1001: e = st;
      16'h1002: e = bh;
      16'h1003: e = bl;
      16'h1004: e = s1;
      16'h1005: e = s2;
      16'h1006: e = {2'b00, slot};
      default: e = 8'h00;
    endcase
    chk("read_data", io_rdata, e);
    chk("io_hit", {7'h00, hit}, {7'h00, a >= 16'h1000 && a <= 16'h1006});
  endtask
  task automatic bus(input logic [15:0] a);
    vsm_far_end_inst.access(a);
    if (bl[3] && a[15:4] == {bh, bl[7:4]}) begin
      if (a[3:0] == 4'h1) st[0] = 1'b1;
      if (a[3:0] == 4'h3) st[1] = 1'b1;
    end
    #1 irq_chk();
  endtask
  task automatic reset_all();
    {st, bh, bl, s1, s2} = '0;
    @(posedge mclk_in);
    rstn_in <= 1'b0;
    repeat (12) @(posedge mclk_in);
    rstn_in <= 1'b1;
    for (int a = 0; a < 8; a++) rd_chk(16'h1000 + 16'(a));
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // about 1600 cycles expected, nearly twenty times that is a hang
  initial begin
    repeat (30000) @(posedge mclk_in);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    reset_all();
    wr(16'h1001, 8'hF0);
    for (int b = 0; b < 8; b++) begin
      wr(16'h1000, 8'h01 << b);
      rd_chk(16'h1001);
    end
    wr(16'h1002, 8'hA5);
    wr(16'h1003, 8'hCF);
    bus(16'hA5C1);
    bus(16'hA5C3);
    bus(16'hA5D1);
    rd_chk(16'h1001);
    for (int i = 0; i < 600; i++) begin
      seed = lfsr(seed);
      case (seed[1:0])
        2'd0: wr(16'h1000 + 16'(seed[4:2]), seed[15:8]);
        2'd1: rd_chk(16'h1000 + 16'(seed[4:2]));
        2'd2: bus(seed[5] ? {bh, bl[7:4], seed[15:12]} : seed);
        default: begin
          vsm_far_end_inst.set_slot(seed[13:8]);
          slot = seed[13:8];
          repeat (3) @(posedge mclk_in);
        end
      endcase
    end
    reset_all();
    tally_and_finish();
  end
endmodule
`default_nettype wire
